//--- isrc_map.sv
// Purpose: Collects the peripheral interrupt flags onto the 40 controller inputs.
// Assumes: Peripherals report flag events and software accesses as one-cycle strobes.
// Notes:   Requests are registered levels; there is no edge detection anywhere.
// Function
// - A source requests only while its local enable bit is set.
// - A request stays asserted until its flag is cleared, by software or, for command done, by the flash module.
// - Inputs 0-3 are converter queue flags, cleared by writing zero after reading one.
// - Input 4 is the SPI mode fault, cleared by control write after read.
// - Input 5 is SPI transfer done, cleared by data access after read.
// - Inputs 6-10 are serial port one; transmit clears on write, receive on read.
// - Inputs 16-22 are timer one: channels 0-3, overflow, accumulator input, overflow.
// - Timer flags clear on write one, or register access under fast clear.
// - Inputs 23-29 are timer two, ordered and cleared like timer one.
// - Inputs 30-31 are interval timer flags, cleared by write one or modulus write.
// - Input 32 joins edge line 0 and the low voltage flag, both write-one-clear.
// - Input 33 joins edge line 1, flash buffer empty and self-clearing command done.
// - No edge detection; every input is a level request.
`timescale 1ns/1ps
`include "isrc_defs.svh"
module isrc_map
    import isrc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [42:0] flag_set,
    input  wire logic [42:0] local_en,
    input  wire logic [42:0] status_read,
    input  wire isrc_clear_s clr,
    output logic      [42:0] flag_status,
    output logic      [39:0] irq_req
);
    isrc_state_s s_reg;
    isrc_state_s s_next;
    logic [42:0] clr_seq;
    logic [42:0] clr_now;
    logic [42:0] flag_req;

    // Map every peripheral clearing action onto the flag it acts on.
    always_comb begin
        clr_seq = '0;
        clr_now = '0;
        for (int i = 0; i < `ISRC_ADC_SRCS; i++) begin
            clr_seq[`ISRC_ADC_BASE + i] = clr.adc_flag_wr_zero[i];
        end
        clr_seq[`ISRC_SPI_FAULT_IDX] = clr.spi_control_reg_one_wr;
        clr_seq[`ISRC_SPI_DONE_IDX]  = clr.spi_data_reg_acc;
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < `ISRC_SER_SRCS; k++) begin
                // Port two sits right after port one with the same layout.
                clr_seq[`ISRC_SER1_BASE + p * `ISRC_SER_SRCS + k] = (k < `ISRC_SER_TX_SRCS) ?
                    clr.serial_data_low_wr[p] : clr.serial_data_low_rd[p];
            end
        end
        for (int t = 0; t < 2; t++) begin
            for (int k = 0; k < `ISRC_TMR_SRCS; k++) begin
                if (k < `ISRC_TMR_CHANNELS) begin
                    clr_now[`ISRC_TMR1_BASE + t * `ISRC_TMR_SRCS + k] =
                        clr.timer_flag_w1c[t * `ISRC_TMR_SRCS + k] |
                        (clr.fast_flag_clear_enable[t] &
                         clr.capture_compare_acc[t * `ISRC_TMR_CHANNELS + k]);
                end else if (k == `ISRC_TMR_OVF_OFS) begin
                    clr_now[`ISRC_TMR1_BASE + t * `ISRC_TMR_SRCS + k] =
                        clr.timer_flag_w1c[t * `ISRC_TMR_SRCS + k] |
                        (clr.fast_flag_clear_enable[t] & clr.timer_counter_acc[t]);
                end else begin
                    clr_now[`ISRC_TMR1_BASE + t * `ISRC_TMR_SRCS + k] =
                        clr.timer_flag_w1c[t * `ISRC_TMR_SRCS + k] |
                        (clr.fast_flag_clear_enable[t] & clr.pulse_accum_acc[t]);
                end
            end
            clr_now[`ISRC_INTERVAL_TIMER_ONE_IDX + t] = clr.interval_timer_flag_w1c[t] |
                                          clr.interval_modulus_wr[t];
        end
        clr_now[`ISRC_EDGE0_IDX] = clr.edge_flag_w1c[0];
        clr_now[`ISRC_EDGE1_IDX] = clr.edge_flag_w1c[1];
        for (int e = 2; e < `ISRC_EDGE_LINES; e++) begin
            clr_now[`ISRC_EDGE2_IDX + e - 2] = clr.edge_flag_w1c[e];
        end
        clr_now[`ISRC_LVD_IDX]        = clr.low_voltage_flag_w1c;
        clr_now[`ISRC_FLASH_BUF_IDX]  = clr.flash_buffer_empty_w1c;
        // The flash module retires command done by itself.
        clr_now[`ISRC_FLASH_DONE_IDX] = clr.flash_command_done_clr;
    end

    genvar g;
    generate
        for (g = 0; g < `ISRC_NUM_FLAGS; g++) begin : g_flag
            isrc_flag u_flag (
                .clk     (clk),
                .rst     (rst),
                .ce      (ce),
                .set     (flag_set[g]),
                .en      (local_en[g]),
                .rd_seen (status_read[g]),
                .clr_seq (clr_seq[g]),
                .clr_now (clr_now[g]),
                .flag    (flag_status[g]),
                .req     (flag_req[g])
            );
        end
    endgenerate

    // Plain levels combined; a pulse from a source must be caught in its own flag.
    always_comb begin
        s_next = s_reg;
        s_next.req = flag_req[`ISRC_NUM_INPUTS-1:0];
        s_next.req[`ISRC_EDGE0_IDX] = flag_req[`ISRC_EDGE0_IDX] | flag_req[`ISRC_LVD_IDX];
        s_next.req[`ISRC_EDGE1_IDX] = flag_req[`ISRC_EDGE1_IDX] | flag_req[`ISRC_FLASH_BUF_IDX] |
                                      flag_req[`ISRC_FLASH_DONE_IDX];
    end

    // The output register costs one cycle but keeps the controller inputs glitch free.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign irq_req = s_reg.req;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_req_needs_enable: assert property ((ce && !local_en[5]) |=> !irq_req[5])
        else $error("request raised with its local enable clear");
    a_req_held_flag: assert property ((ce && flag_status[9] && local_en[9]) |=> irq_req[9])
        else $error("request dropped while flag and enable stand");
    a_adc_clear_seq: assert property (
        (ce && flag_status[0] && status_read[0]) ##1 (ce && clr.adc_flag_wr_zero[0] && !flag_set[0])
        |=> !flag_status[0])
        else $error("converter flag not cleared by write zero after read");
    a_adc_map: assert property (
        (ce && flag_status[2] && local_en[2]) |=> irq_req[2])
        else $error("converter queue two pause flag not on its input");
    a_spi_fault_clr: assert property (
        (ce && flag_status[4] && status_read[4]) ##1 (ce && clr.spi_control_reg_one_wr && !flag_set[4])
        |=> !flag_status[4])
        else $error("mode fault not cleared by control write after read");
    a_spi_done_clr: assert property (
        (ce && flag_status[5] && status_read[5]) ##1 (ce && clr.spi_data_reg_acc && !flag_set[5])
        |=> !flag_status[5] ##1 (!$past(ce) || !irq_req[5]))
        else $error("transfer done not cleared by data access after read");
    a_ser_rx_clear: assert property (
        (ce && flag_status[8] && status_read[8]) ##1 (ce && clr.serial_data_low_rd[0] && !flag_set[8])
        |=> !flag_status[8])
        else $error("receive flag not cleared by data read after read");
    a_ser1_tx_clear: assert property (
        (ce && flag_status[7] && status_read[7]) ##1 (ce && clr.serial_data_low_wr[0] && !flag_set[7])
        |=> !flag_status[7])
        else $error("transmit complete flag not cleared by data write after read");
    a_ser2_tx_clear: assert property (
        (ce && flag_status[11] && status_read[11]) ##1 (ce && clr.serial_data_low_wr[1] && !flag_set[11])
        |=> !flag_status[11])
        else $error("second port transmit flag not cleared by data write");
    a_ser2_rx_clear: assert property (
        (ce && flag_status[15] && status_read[15]) ##1 (ce && clr.serial_data_low_rd[1] && !flag_set[15])
        |=> !flag_status[15])
        else $error("second port idle flag not cleared by data read");
    a_tmr_ovf_map: assert property ((ce && flag_status[20] && local_en[20]) |=> irq_req[20])
        else $error("timer overflow not on its input");
    a_tmr_fast_clr: assert property (
        (ce && clr.fast_flag_clear_enable[0] && clr.timer_counter_acc[0] && !flag_set[20])
        |=> !flag_status[20])
        else $error("fast flag clear by counter access failed");
    a_tmr_w1c_clr: assert property (
        (ce && clr.timer_flag_w1c[0] && !flag_set[16]) |=> !flag_status[16])
        else $error("timer channel flag not cleared by write one");
    a_tmr_chan_clr: assert property (
        (ce && clr.fast_flag_clear_enable[0] && clr.capture_compare_acc[2] && !flag_set[18]) |=> !flag_status[18])
        else $error("fast flag clear by channel access failed");
    a_fast_off_keep: assert property (
        (ce && flag_status[19] && !clr.fast_flag_clear_enable[0] && !clr.timer_flag_w1c[3]) |=> flag_status[19])
        else $error("channel flag cleared with fast clear off");
    a_tmr2_accum_clr: assert property (
        (ce && clr.fast_flag_clear_enable[1] && clr.pulse_accum_acc[1] && !flag_set[28])
        |=> !flag_status[28])
        else $error("second timer accumulator flag not cleared");
    a_tmr2_map: assert property (
        (ce && flag_status[26] && local_en[26]) |=> irq_req[26])
        else $error("second timer channel three not on its input");
    a_pit_modulus_clr: assert property (
        (ce && clr.interval_modulus_wr[1] && !flag_set[31])
        |=> !flag_status[31] ##1 (!$past(ce) || !irq_req[31]))
        else $error("interval flag not cleared by modulus write");
    a_pit_w1c_clr: assert property (
        (ce && clr.interval_timer_flag_w1c[0] && !flag_set[30]) |=> !flag_status[30])
        else $error("interval flag not cleared by write one");
    a_edge0_clear: assert property (
        (ce && clr.edge_flag_w1c[0] && !flag_set[32]) |=> !flag_status[32])
        else $error("edge flag zero not cleared by write one");
    a_lvd_clear: assert property (
        (ce && clr.low_voltage_flag_w1c && !flag_set[40]) |=> !flag_status[40])
        else $error("low voltage flag not cleared by write one");
    a_flash_buf_clr: assert property (
        (ce && clr.flash_buffer_empty_w1c && !flag_set[41]) |=> !flag_status[41])
        else $error("flash buffer empty flag not cleared by write one");
    a_flash_done_clr: assert property (
        (ce && clr.flash_command_done_clr && !flag_set[42]) |=> !flag_status[42])
        else $error("command done flag not retired by its automatic clear");
    a_edge2_clear: assert property (
        (ce && clr.edge_flag_w1c[2] && !flag_set[34]) |=> !flag_status[34])
        else $error("edge flag two not cleared by write one");
    a_ce_freeze: assert property (
        !ce |=> ($stable(irq_req) && $stable(flag_status)))
        else $error("state changed while the clock enable was low");
    a_shared_lvd: assert property ((ce && flag_status[40] && local_en[40]) |=> irq_req[32])
        else $error("low voltage flag missing on shared input");
    a_shared_flash: assert property ((ce && flag_status[42] && local_en[42]) |=> irq_req[33])
        else $error("command done flag missing on shared input");
    a_edge7_clear: assert property ((ce && clr.edge_flag_w1c[7] && !flag_set[39]) |=> !flag_status[39])
        else $error("edge flag seven not cleared by write one");
    a_level_only: assert property ((ce && !flag_status[35] && !flag_set[35])[*2] |=> !irq_req[35])
        else $error("request seen without a standing flag");
    a_shared_or: assert property ((ce && !flag_req[32] && !flag_req[40]) |=> !irq_req[32])
        else $error("shared input raised with no enabled flag");

    c_flash_shared: cover property (ce && flag_req[42] && !flag_req[33] && !flag_req[41] ##1 irq_req[33]);
    c_fast_clear: cover property (flag_status[16] ##1 (ce && clr.fast_flag_clear_enable[0]) ##1 !flag_status[16]);
    c_ser_rx_seq: cover property (irq_req[13] ##[1:20] !irq_req[13]);
    c_set_on_clear: cover property (ce && flag_set[39] && clr.edge_flag_w1c[7]);
    c_shared_lvd: cover property (ce && flag_req[40] && !flag_req[32] ##1 irq_req[32]);

endmodule : isrc_map

//--- isrc_defs.svh
// Purpose: Source numbering and flag indices of the interrupt source mapping.
// Assumes: Flags 0..39 map one to one onto controller inputs; 40..42 are extra shared flags.
// Notes:   Definitions only.
`ifndef ISRC_DEFS_SVH
`define ISRC_DEFS_SVH

`define ISRC_NUM_INPUTS    40
`define ISRC_NUM_FLAGS     43
`define ISRC_ADC_BASE      0
`define ISRC_ADC_SRCS      4
`define ISRC_SPI_FAULT_IDX 4
`define ISRC_SPI_DONE_IDX  5
`define ISRC_SER1_BASE     6
`define ISRC_SER2_BASE     11
`define ISRC_SER_SRCS      5
`define ISRC_SER_TX_SRCS   2
`define ISRC_TMR1_BASE     16
`define ISRC_TMR2_BASE     23
`define ISRC_TMR_SRCS      7
`define ISRC_TMR_CHANNELS  4
`define ISRC_TMR_OVF_OFS   4
`define ISRC_INTERVAL_TIMER_ONE_IDX      30
`define ISRC_EDGE0_IDX     32
`define ISRC_EDGE1_IDX     33
`define ISRC_EDGE2_IDX     34
`define ISRC_EDGE_LINES    8
`define ISRC_LVD_IDX       40
`define ISRC_FLASH_BUF_IDX 41
`define ISRC_FLASH_DONE_IDX 42

`endif

//--- isrc_pkg.sv
// Purpose: Types shared by the interrupt source mapping modules.
// Assumes: Nothing beyond the index header.
// Notes:   Clear strobes travel together as one struct.
package isrc_pkg;

    typedef struct packed {
        logic flag;
        logic armed;
    } isrc_cell_s;

    typedef struct packed {
        logic [39:0] req;
    } isrc_state_s;

    typedef struct packed {
        logic [3:0]  adc_flag_wr_zero;
        logic        spi_control_reg_one_wr;
        logic        spi_data_reg_acc;
        logic [1:0]  serial_data_low_wr;
        logic [1:0]  serial_data_low_rd;
        logic [13:0] timer_flag_w1c;
        logic [1:0]  fast_flag_clear_enable;
        logic [7:0]  capture_compare_acc;
        logic [1:0]  timer_counter_acc;
        logic [1:0]  pulse_accum_acc;
        logic [1:0]  interval_timer_flag_w1c;
        logic [1:0]  interval_modulus_wr;
        logic [7:0]  edge_flag_w1c;
        logic        low_voltage_flag_w1c;
        logic        flash_buffer_empty_w1c;
        logic        flash_command_done_clr;
    } isrc_clear_s;

endpackage : isrc_pkg

//--- isrc_flag.sv
// Purpose: One sticky interrupt flag with local enable and its clearing sequence.
// Assumes: All strobes are synchronous one-cycle pulses.
// Notes:   A sequenced clear only acts after the flag was read as set.
`timescale 1ns/1ps
module isrc_flag
    import isrc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic set,
    input  wire logic en,
    input  wire logic rd_seen,
    input  wire logic clr_seq,
    input  wire logic clr_now,
    output logic      flag,
    output logic      req
);
    isrc_cell_s s_reg;
    isrc_cell_s s_next;

    always_comb begin
        s_next = s_reg;
        if (rd_seen && s_reg.flag) begin
            s_next.armed = 1'b1;
        end
        if (clr_now || (clr_seq && s_reg.armed)) begin
            s_next.flag  = 1'b0;
            s_next.armed = 1'b0;
        end
        // An event in the clearing cycle is kept, so no request is lost.
        if (set) begin
            s_next.flag = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign flag = s_reg.flag;
    assign req  = s_reg.flag & en;

    a_set_wins_clear: assert property (@(posedge clk) disable iff (rst) (ce && set) |=> flag)
        else $error("flag lost an event that arrived with its clear");
    a_clear_needs_arm: assert property (@(posedge clk) disable iff (rst)
        (ce && flag && !s_reg.armed && !clr_now && !set) |=> flag)
        else $error("flag cleared without a prior read as set");

endmodule : isrc_flag

//--- isrc_src_model.sv
// Purpose: Behavioural peripheral side that raises one flag event on command.
// Assumes: The bench drives go and idx just after a rising clock edge.
// Notes:   Events leave here as one-cycle pulses, so the map never needs edge detection.
`timescale 1ns/1ps
module isrc_src_model
    import isrc_pkg::*;
(
    input  wire logic        go,
    input  wire logic [5:0]  idx,
    output logic      [42:0] flag_set
);
    // A held level would keep setting the flag, so an event lasts one cycle only.
    always_comb begin
        flag_set = '0;
        if (go) begin
            flag_set[idx] = 1'b1;
        end
    end
endmodule : isrc_src_model

//--- isrc_map_bench.sv
// Purpose: Self-checking bench for the interrupt source mapping.
// Assumes: Inputs change 1 ns after the rising edge; the map answers one cycle per stage.
// Notes:   Every flag is set and cleared by each of its clear paths, with refused clears first for flags 0-15 and, in the second pass, 16-29.
`timescale 1ns/1ps
module isrc_map_bench
    import isrc_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        ce;
    logic        go;
    logic [5:0]  idx;
    logic [42:0] flag_set;
    logic [42:0] local_en;
    logic [42:0] status_read;
    logic [42:0] flag_status;
    logic [42:0] exp_f;
    logic [39:0] irq_req;
    logic [31:0] lfsr;
    isrc_clear_s clr;
    int          n_fail;
    int          checked;
    int          cyc;
    isrc_src_model src (.go(go), .idx(idx), .flag_set(flag_set));
    isrc_map dut (.clk(clk), .rst(rst), .ce(ce), .flag_set(flag_set), .local_en(local_en),
                  .status_read(status_read), .clr(clr), .flag_status(flag_status), .irq_req(irq_req));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [31:0] nxt(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    // Shared inputs are worked out here so a wrong pairing in the map shows up.
    function automatic logic [39:0] exp_irq(logic [42:0] f, logic [42:0] e);
        logic [42:0] r;
        r = f & e;
        return {r[39:34], r[33] | r[41] | r[42], r[32] | r[40], r[31:0]};
    endfunction : exp_irq
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(logic [42:0] got, logic [42:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_all();
        chk(flag_status, exp_f);
        chk({3'h0, irq_req}, {3'h0, exp_irq(exp_f, local_en)});
    endtask : chk_all
    task automatic close_out();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    task automatic set_flag(int i);
        go = 1'b1;
        idx = i[5:0];
        tick();
        go = 1'b0;
        exp_f[i] = 1'b1;
    endtask : set_flag
    task automatic arm(int i);
        status_read[i] = 1'b1;
        tick();
        status_read = '0;
    endtask : arm
    // Mode 0 is the plain clear, 1 the alternate path, 2 a fast access with fast clear off.
    task automatic do_clr(int i, int m);
        isrc_clear_s c;
        int          t;
        int          k;
        c = '0;
        t = (i - 16) / 7;
        k = (i - 16) % 7;
        if (i < 4) c.adc_flag_wr_zero[i] = 1'b1;
        else if (i == 4) c.spi_control_reg_one_wr = 1'b1;
        else if (i == 5) c.spi_data_reg_acc = 1'b1;
        else if (i < 16 && (i - 6) % 5 < 2) c.serial_data_low_wr[(i - 6) / 5] = 1'b1;
        else if (i < 16) c.serial_data_low_rd[(i - 6) / 5] = 1'b1;
        else if (i < 30 && m == 0) c.timer_flag_w1c[i - 16] = 1'b1;
        else if (i < 30) begin
            c.fast_flag_clear_enable[t] = (m == 1);
            if (k < 4) c.capture_compare_acc[t * 4 + k] = 1'b1;
            else if (k == 4) c.timer_counter_acc[t] = 1'b1;
            else c.pulse_accum_acc[t] = 1'b1;
        end
        else if (i < 32 && m == 0) c.interval_timer_flag_w1c[i - 30] = 1'b1;
        else if (i < 32) c.interval_modulus_wr[i - 30] = 1'b1;
        else if (i < 40) c.edge_flag_w1c[i - 32] = 1'b1;
        else if (i == 40) c.low_voltage_flag_w1c = 1'b1;
        else if (i == 41) c.flash_buffer_empty_w1c = 1'b1;
        else c.flash_command_done_clr = 1'b1;
        clr = c;
        tick();
        clr = '0;
    endtask : do_clr
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        go = 1'b0;
        idx = '0;
        local_en = '0;
        status_read = '0;
        clr = '0;
        exp_f = '0;
        lfsr = 32'had7d;
        repeat (16) tick();
        rst = 1'b0;
        chk_all();
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 43; i++) begin
                lfsr = nxt(lfsr);
                local_en = {lfsr[10:0], lfsr};
                local_en[i] = 1'b1;
                set_flag(i);
                tick();
                chk_all();
                local_en[i] = 1'b0;
                tick();
                chk_all();
                local_en[i] = 1'b1;
                if (i < 16) do_clr(i, 0);
                else if (i < 30 && m == 1) do_clr(i, 2);
                tick();
                chk_all();
                if (i < 16) arm(i);
                do_clr(i, m);
                exp_f[i] = 1'b0;
                tick();
                chk_all();
            end
        end
        local_en = '1;
        // A read while the flag is clear must not arm a later sequenced clear.
        arm(9);
        set_flag(9);
        do_clr(9, 0);
        tick();
        chk_all();
        set_flag(32);
        tick();
        set_flag(40);
        do_clr(32, 0);
        exp_f[32] = 1'b0;
        tick();
        chk_all();
        ce = 1'b0;
        set_flag(3);
        exp_f[3] = 1'b0;
        ce = 1'b1;
        tick();
        chk_all();
        go = 1'b1;
        idx = 6'h14;
        do_clr(20, 0);
        go = 1'b0;
        exp_f[20] = 1'b1;
        tick();
        chk_all();
        rst = 1'b1;
        tick();
        rst = 1'b0;
        exp_f = '0;
        tick();
        chk_all();
        close_out();
    end
endmodule : isrc_map_bench
